// ===== rtl/lpmc_cfg.svh
/*
 * constants for the low power mode controller: mode codes, clock limits,
 * oscillator defaults and wake timing.
 * assumes a single 40 MHz core clock.
 */
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define LPMC_CORE_CLK_HZ 40000000
`define LPMC_RANGE1_MAX_HZ 48000000
`define LPMC_RANGE2_MAX_HZ 16000000
`define LPMC_LOW_POWER_RUN_MAX_HZ 2000000
`define LPMC_WAKE_MSI_HZ 4000000
`define LPMC_MSI_MAX_HZ 48000000
`define LPMC_WAKE_DELAY_NS 500
`define LPMC_WAKE_CYCLES (((`LPMC_WAKE_DELAY_NS * 40) + 999) / 1000)

// ----------------------------------------
// mode request codes
// ----------------------------------------
`define LPMC_REQ_STOP0 3'h0
`define LPMC_REQ_STOP1 3'h1
`define LPMC_REQ_STOP2 3'h2
`define LPMC_REQ_STANDBY 3'h3
`define LPMC_REQ_SHUTDOWN 3'h4

// ----------------------------------------
// misc
// ----------------------------------------
`define LPMC_VBAT_ADC_CHANNEL 5'h0e
`define LPMC_THRESH_LOWEST 3'h0
`define LPMC_GPIO_ANALOG 2'h3

`endif

// ===== rtl/lpmc_pkg.sv
/*
 * types for the low power mode controller.
 * assumes lpmc_cfg.svh is compiled alongside.
 */
`default_nettype none

package lpmc_pkg;

    typedef enum logic [3:0] {
        LPMC_RUN = 4'h0,
        LPMC_SLEEP = 4'h1,
        LPMC_LOW_POWER_RUN = 4'h2,
        LPMC_LOW_POWER_SLEEP = 4'h3,
        LPMC_STOP0 = 4'h4,
        LPMC_STOP1 = 4'h5,
        LPMC_STOP2 = 4'h6,
        LPMC_STANDBY = 4'h7,
        LPMC_SHUTDOWN = 4'h8,
        LPMC_WAKE = 4'h9
    } lpmc_mode_e;

    // supply and oscillator control bundle
    typedef struct packed {
        logic main_regulator;
        logic low_power_regulator;
        logic core_supply_domain;
        logic core_partial_off;
        logic sram_bank_one;
        logic sram_bank_two;
        logic cpu_clk;
        logic periph_clk;
        logic pll;
        logic multispeed_oscillator;
        logic fast_internal_rc;
        logic external_crystal_clock;
        logic slow_internal_rc;
        logic slow_external_crystal;
    } lpmc_power_s;

    typedef logic [1:0] lpmc_gpio_t;

endpackage : lpmc_pkg

`default_nettype wire

// ===== rtl/lpmc_sync.sv
/*
 * three-stage synchroniser; a change is accepted once stages two and
 * three agree. assumes the input is asynchronous to CORE_CLK.
 */
`default_nettype none

module lpmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    // ----------------------------------------
    // shift chain
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // accept bit once two later stages agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    dout[i] <= 1'b0;
                else if (s2_reg[i] == s3_reg[i])
                    dout[i] <= s3_reg[i];
            end
        end
    endgenerate

endmodule : lpmc_sync

`default_nettype wire

// ===== rtl/lpmc_top.sv
/*
 * low power mode controller: core range, run/sleep/stop/standby/shutdown
 * sequencing, supply gating, wake clock choice, supply mode, pin default.
 * assumes CPU requests are on CORE_CLK; supply and wake pins are async.
 */
`default_nettype none

`include "lpmc_cfg.svh"

// Behaviour
// - both regulators enabled after reset
// - range one: up to 48 MHz
// - range two: clock limit 16 MHz
// - battery domain on battery when supply absent
// - battery-only: interrupts and alarms never wake
// - battery pin divided by three to channel 14
// - reset starts in run, range one
// - sleep stops CPU clock only, any interrupt wakes
// - low-power run needs clock below 2 MHz
// - low-power sleep only from low-power run
// - stop 0/1 retain memory, stop fast oscillators
// - stop 0 main regulator, stop 1 low-power
// - wake peripherals may request fast RC in stop
// - stop exit uses software-chosen wake clock
// - stop 2 partial core off, gating like stop 1
// - retention bit: bank two kept in standby
// - no retention: both regulators off in standby
// - standby forces detector lowest threshold
// - standby exit on multispeed at 4 MHz
// - shutdown keeps slow crystal only, 4 MHz exit
// - shutdown disables supply monitoring
// - general pins analog during and after reset
// - linear supply after reset, switched wins
module lpmc_top
    import lpmc_pkg::*;
#(
    parameter int NUM_GPIO = 16,
    parameter int WAKE_CYCLES = `LPMC_WAKE_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic SLEEP_REQ,
    input wire logic DEEP_SLEEP,
    input wire logic [2:0] LP_MODE_SEL,
    input wire logic LP_RUN_REQ,
    input wire logic [25:0] SYSCLK_HZ,
    input wire logic RANGE_LOW_SEL,
    input wire logic WAKE_HSI_SEL,
    input wire logic STANDBY_RETENTION_BIT,
    input wire logic KEEP_SLOW_INTERNAL,
    input wire logic KEEP_SLOW_EXTERNAL,
    input wire logic DETECTOR_EN,
    input wire logic [2:0] DETECTOR_LEVEL,
    input wire logic SWITCHED_SEL,
    input wire logic VBAT_MON_EN,
    input wire logic INTERRUPT,
    input wire logic WAKE_PIN,
    input wire logic RTC_ALARM,
    input wire logic MAIN_SUPPLY_OK,
    input wire logic HSI_WAKE_REQ,
    output lpmc_mode_e MODE,
    output lpmc_power_s POWER,
    output logic RANGE_LOW,
    output logic FLASH_SLOW_READ,
    output logic FLASH_PROG_OK,
    output logic CLOCK_LIMIT_ERR,
    output logic [25:0] WAKE_CLK_HZ,
    output logic WAKE_CLK_HSI,
    output logic DETECTOR_ON,
    output logic [2:0] DETECTOR_THRESH,
    output logic SUPPLY_MONITOR_ON,
    output logic SWITCHED_MODE,
    output logic ON_BATTERY,
    output logic VBAT_DIVIDER_EN,
    output logic [4:0] VBAT_ADC_CHANNEL,
    output lpmc_gpio_t [NUM_GPIO-1:0] GPIO_MODE
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    lpmc_mode_e mode_reg;
    lpmc_mode_e mode_next;
    lpmc_mode_e resume_reg;
    logic [15:0] wake_cnt_reg;
    logic [2:0] async_in;
    logic [2:0] async_sync;
    logic wake_pin_s;
    logic alarm_s;
    logic supply_ok_s;
    logic any_wake;
    logic range_low_reg;
    logic [25:0] hz_limit;

    // async pins synchronised; supply carried as absent so reset reads present
    assign async_in = {~MAIN_SUPPLY_OK, RTC_ALARM, WAKE_PIN};

    lpmc_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .din(async_in),
        .dout(async_sync)
    );

    assign wake_pin_s = async_sync[0];
    assign alarm_s = async_sync[1];
    assign supply_ok_s = ~async_sync[2];

    lpmc_vbat u_vbat (
        .clk(CORE_CLK),
        .rst(RST),
        .main_present(supply_ok_s),
        .monitor_en(VBAT_MON_EN),
        .on_battery(ON_BATTERY),
        .divider_en(VBAT_DIVIDER_EN),
        .adc_channel(VBAT_ADC_CHANNEL)
    );

    // no wake while the main supply is absent
    assign any_wake = supply_ok_s & (INTERRUPT | wake_pin_s | alarm_s);

    // ----------------------------------------
    // mode helpers
    // ----------------------------------------
    function automatic lpmc_mode_e deep_mode(input logic [2:0] sel);
        case (sel)
            `LPMC_REQ_STOP0: deep_mode = LPMC_STOP0;
            `LPMC_REQ_STOP1: deep_mode = LPMC_STOP1;
            `LPMC_REQ_STOP2: deep_mode = LPMC_STOP2;
            `LPMC_REQ_STANDBY: deep_mode = LPMC_STANDBY;
            `LPMC_REQ_SHUTDOWN: deep_mode = LPMC_SHUTDOWN;
            default: deep_mode = LPMC_STOP0;
        endcase
    endfunction : deep_mode

    function automatic logic is_stop(input lpmc_mode_e m);
        is_stop = (m == LPMC_STOP0) || (m == LPMC_STOP1) || (m == LPMC_STOP2);
    endfunction : is_stop

    function automatic logic is_off(input lpmc_mode_e m);
        is_off = (m == LPMC_STANDBY) || (m == LPMC_SHUTDOWN);
    endfunction : is_off

    // ----------------------------------------
    // mode sequencer
    // ----------------------------------------
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            LPMC_RUN:
            begin
                if (SLEEP_REQ && DEEP_SLEEP)
                    mode_next = deep_mode(LP_MODE_SEL);
                else if (SLEEP_REQ)
                    mode_next = LPMC_SLEEP;
                else if (LP_RUN_REQ && SYSCLK_HZ < 26'(`LPMC_LOW_POWER_RUN_MAX_HZ))
                    mode_next = LPMC_LOW_POWER_RUN;
            end
            LPMC_LOW_POWER_RUN:
            begin
                if (SLEEP_REQ && DEEP_SLEEP)
                    mode_next = deep_mode(LP_MODE_SEL);
                else if (SLEEP_REQ)
                    mode_next = LPMC_LOW_POWER_SLEEP;
                else if (!LP_RUN_REQ || SYSCLK_HZ >= 26'(`LPMC_LOW_POWER_RUN_MAX_HZ))
                    mode_next = LPMC_RUN;
            end
            LPMC_SLEEP:
                if (any_wake)
                    mode_next = LPMC_RUN;
            LPMC_LOW_POWER_SLEEP:
                if (any_wake)
                    mode_next = LPMC_LOW_POWER_RUN;
            LPMC_STOP0, LPMC_STOP1, LPMC_STOP2, LPMC_STANDBY, LPMC_SHUTDOWN:
                if (any_wake)
                    mode_next = LPMC_WAKE;
            LPMC_WAKE:
                if (wake_cnt_reg == 16'(WAKE_CYCLES - 1))
                    mode_next = LPMC_RUN;
            default: mode_next = LPMC_RUN;
        endcase
    end

    // mode register, run after reset
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            mode_reg <= LPMC_RUN;
        else
            mode_reg <= mode_next;
    end

    // remember the mode that is being left for wake clock choice
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            resume_reg <= LPMC_RUN;
        end
        else if (mode_next != mode_reg && mode_next == LPMC_WAKE)
        begin
            resume_reg <= mode_reg;
        end
    end

    // wake settle counter
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            wake_cnt_reg <= 16'h0000;
        else if (mode_reg == LPMC_WAKE)
            wake_cnt_reg <= wake_cnt_reg + 16'h0001;
        else
            wake_cnt_reg <= 16'h0000;
    end

    // ----------------------------------------
    // wake clock selection
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            WAKE_CLK_HZ <= 26'(`LPMC_WAKE_MSI_HZ);
            WAKE_CLK_HSI <= 1'b0;
        end
        else if (mode_reg == LPMC_WAKE)
        begin
            if (is_off(resume_reg))
            begin
                WAKE_CLK_HZ <= 26'(`LPMC_WAKE_MSI_HZ);
                WAKE_CLK_HSI <= 1'b0;
            end
            else
            begin
                WAKE_CLK_HZ <= SYSCLK_HZ > 26'(`LPMC_MSI_MAX_HZ) ? 26'(`LPMC_MSI_MAX_HZ) : SYSCLK_HZ;
                WAKE_CLK_HSI <= WAKE_HSI_SEL;
            end
        end
    end

    // ----------------------------------------
    // voltage range and flash timing
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            range_low_reg <= 1'b0;
        else if (mode_reg == LPMC_RUN)
            range_low_reg <= RANGE_LOW_SEL;
    end

    assign hz_limit = range_low_reg ? 26'(`LPMC_RANGE2_MAX_HZ) : 26'(`LPMC_RANGE1_MAX_HZ);

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            RANGE_LOW <= 1'b0;
            FLASH_SLOW_READ <= 1'b0;
            FLASH_PROG_OK <= 1'b1;
            CLOCK_LIMIT_ERR <= 1'b0;
        end
        else
        begin
            RANGE_LOW <= range_low_reg;
            FLASH_SLOW_READ <= range_low_reg;
            FLASH_PROG_OK <= 1'b1;
            CLOCK_LIMIT_ERR <= SYSCLK_HZ > hz_limit;
        end
    end

    // ----------------------------------------
    // supply and clock gating per mode
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            POWER <= '1;
        end
        else
        begin
            POWER.main_regulator <= mode_reg == LPMC_RUN || mode_reg == LPMC_SLEEP ||
                mode_reg == LPMC_STOP0 || mode_reg == LPMC_WAKE;
            POWER.low_power_regulator <= (mode_reg != LPMC_SHUTDOWN) &&
                !(mode_reg == LPMC_STANDBY && !STANDBY_RETENTION_BIT);
            POWER.core_supply_domain <= !is_off(mode_reg);
            POWER.core_partial_off <= mode_reg == LPMC_STOP2;
            POWER.sram_bank_one <= !is_off(mode_reg);
            POWER.sram_bank_two <= !is_off(mode_reg) ||
                (mode_reg == LPMC_STANDBY && STANDBY_RETENTION_BIT);
            POWER.cpu_clk <= mode_reg == LPMC_RUN || mode_reg == LPMC_LOW_POWER_RUN ||
                mode_reg == LPMC_WAKE;
            POWER.periph_clk <= !is_stop(mode_reg) && !is_off(mode_reg);
            POWER.pll <= !is_stop(mode_reg) && !is_off(mode_reg);
            POWER.multispeed_oscillator <= !is_stop(mode_reg) && !is_off(mode_reg);
            POWER.fast_internal_rc <= (!is_stop(mode_reg) && !is_off(mode_reg)) ||
                (is_stop(mode_reg) && HSI_WAKE_REQ);
            POWER.external_crystal_clock <= !is_stop(mode_reg) && !is_off(mode_reg);
            POWER.slow_internal_rc <= mode_reg != LPMC_SHUTDOWN && KEEP_SLOW_INTERNAL;
            POWER.slow_external_crystal <= KEEP_SLOW_EXTERNAL;
        end
    end

    // ----------------------------------------
    // supply detector and supply mode
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            DETECTOR_ON <= 1'b0;
            DETECTOR_THRESH <= `LPMC_THRESH_LOWEST;
            SUPPLY_MONITOR_ON <= 1'b1;
            SWITCHED_MODE <= 1'b0;
        end
        else
        begin
            DETECTOR_ON <= DETECTOR_EN && mode_reg != LPMC_SHUTDOWN;
            DETECTOR_THRESH <= mode_reg == LPMC_STANDBY ? `LPMC_THRESH_LOWEST : DETECTOR_LEVEL;
            SUPPLY_MONITOR_ON <= mode_reg != LPMC_SHUTDOWN;
            SWITCHED_MODE <= SWITCHED_SEL && !is_off(mode_reg);
        end
    end

    // ----------------------------------------
    // pin defaults
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_GPIO; g++)
        begin : g_pin
            always_ff @(posedge CORE_CLK or posedge RST)
            begin
                if (RST)
                    GPIO_MODE[g] <= `LPMC_GPIO_ANALOG;
                else
                    GPIO_MODE[g] <= `LPMC_GPIO_ANALOG;
            end
        end
    endgenerate

    assign MODE = mode_reg;

endmodule : lpmc_top

`default_nettype wire

// ===== rtl/lpmc_vbat.sv
/*
 * battery-backed domain switch and battery monitor routing.
 * assumes supply-present input is already synchronised.
 */
`default_nettype none

`include "lpmc_cfg.svh"

module lpmc_vbat (
    input wire logic clk,
    input wire logic rst,
    input wire logic main_present,
    input wire logic monitor_en,
    output logic on_battery,
    output logic divider_en,
    output logic [4:0] adc_channel
);
    // ----------------------------------------
    // battery switch and divider
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            on_battery <= 1'b0;
            divider_en <= 1'b0;
            adc_channel <= 5'h00;
        end
        else
        begin
            on_battery <= ~main_present;
            divider_en <= monitor_en;
            adc_channel <= monitor_en ? `LPMC_VBAT_ADC_CHANNEL : 5'h00;
        end
    end

endmodule : lpmc_vbat

`default_nettype wire

// ===== verif/lpmc_far_model.sv
/*
 * far-side model: main supply and the asynchronous wake sources.
 * assumes the bench sets wanted levels just after CORE_CLK rises.
 */
`default_nettype none

module lpmc_far_model (
    input wire logic clk,
    input wire logic supply_on,
    input wire logic pin_req,
    input wire logic alarm_req,
    output logic main_supply_ok = 1'h1,
    output logic wake_pin = 1'h0,
    output logic rtc_alarm = 1'h0
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // supply and wake lines
    // ----------------------------------------
    // lines move 9 ns after the edge, off the core clock phase
    always @(posedge clk)
    begin
        #9;
        main_supply_ok <= supply_on;
        wake_pin <= pin_req;
        rtc_alarm <= alarm_req;
    end
endmodule : lpmc_far_model

`default_nettype wire

// ===== verif/lpmc_top_chk.sv
/*
 * checker for the low power mode controller, watching top ports only.
 * assumes CORE_CLK and an active-high RST, attached by bind.
 */
`default_nettype none

module lpmc_top_chk
    import lpmc_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic SLEEP_REQ,
    input wire logic DEEP_SLEEP,
    input wire logic [2:0] LP_MODE_SEL,
    input wire logic LP_RUN_REQ,
    input wire logic [25:0] SYSCLK_HZ,
    input wire logic STANDBY_RETENTION_BIT,
    input wire logic HSI_WAKE_REQ,
    input wire logic DETECTOR_EN,
    input wire logic MAIN_SUPPLY_OK,
    input wire lpmc_mode_e MODE,
    input wire lpmc_power_s POWER,
    input wire logic [2:0] DETECTOR_THRESH,
    input wire logic SUPPLY_MONITOR_ON,
    input wire logic ON_BATTERY
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // mode entry and per-mode supply gating
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    chk_deep_entry: assert property (
        MODE == LPMC_RUN && SLEEP_REQ && DEEP_SLEEP && !LP_RUN_REQ |=> MODE == (($past(LP_MODE_SEL) > 3'h4) ?
            LPMC_STOP0 : lpmc_mode_e'({1'h0, $past(LP_MODE_SEL)} + 4'h4)))
        else $error("deep request reached the wrong mode");
    chk_sleep_gate: assert property (
        $stable(MODE) && MODE == LPMC_SLEEP |-> !POWER.cpu_clk && POWER.periph_clk)
        else $error("sleep clock gating wrong");
    chk_stop_supply: assert property (
        $stable(MODE) && MODE inside {LPMC_STOP0, LPMC_STOP1, LPMC_STOP2} |->
            POWER.main_regulator == (MODE == LPMC_STOP0) && (MODE == LPMC_STOP0 || POWER.low_power_regulator)
            && POWER.sram_bank_one && POWER.sram_bank_two && !POWER.cpu_clk && !POWER.periph_clk && !POWER.pll
            && !POWER.multispeed_oscillator && !POWER.external_crystal_clock
            && POWER.core_partial_off == (MODE == LPMC_STOP2))
        else $error("stop supply or clock gating wrong");
    chk_fast_rc_req: assert property (
        (MODE inside {LPMC_STOP0, LPMC_STOP1, LPMC_STOP2} && HSI_WAKE_REQ) [*6] |-> POWER.fast_internal_rc)
        else $error("fast rc not granted in stop");
    chk_standby_keep: assert property (
        $stable(MODE) && MODE == LPMC_STANDBY |-> !POWER.core_supply_domain
            && !POWER.main_regulator && POWER.low_power_regulator == STANDBY_RETENTION_BIT
            && POWER.sram_bank_two == STANDBY_RETENTION_BIT)
        else $error("standby supply wrong");
    chk_detector_low: assert property (
        $stable(MODE) && MODE == LPMC_STANDBY && DETECTOR_EN |-> DETECTOR_THRESH == 3'h0)
        else $error("detector threshold not lowest in standby");
    chk_shutdown_off: assert property (
        $stable(MODE) && MODE == LPMC_SHUTDOWN |-> !SUPPLY_MONITOR_ON && !POWER.core_supply_domain
            && !POWER.pll && !POWER.multispeed_oscillator && !POWER.fast_internal_rc
            && !POWER.slow_internal_rc && !POWER.external_crystal_clock)
        else $error("shutdown left something running");

    // ----------------------------------------
    // battery operation and low-power run gate
    // ----------------------------------------
    chk_battery_switch: assert property (
        $stable(MAIN_SUPPLY_OK) [*8] |-> ON_BATTERY == !MAIN_SUPPLY_OK)
        else $error("battery switch does not follow supply");
    chk_battery_hold: assert property (
        MODE == LPMC_STOP1 ##1 ON_BATTERY [*3] |-> MODE == LPMC_STOP1)
        else $error("woke while on battery");
    chk_low_power_run_gate: assert property (
        MODE == LPMC_RUN && LP_RUN_REQ && !SLEEP_REQ && SYSCLK_HZ >= 26'h1e_8480 |=> MODE != LPMC_LOW_POWER_RUN)
        else $error("low-power run entered at 2 MHz or more");
endmodule : lpmc_top_chk

bind lpmc_top lpmc_top_chk u_chk (.*);

`default_nettype wire

// ===== verif/lpmc_top_tb.sv
/*
 * self-checking bench for lpmc_top with the far-side model.
 * assumes WAKE_CYCLES cut to 2 to keep the run short.
 */
`default_nettype none

module lpmc_top_tb
    import lpmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic CORE_CLK = 1'h0;
    logic RST = 1'h1;
    logic SLEEP_REQ = 1'h0, DEEP_SLEEP = 1'h0, LP_RUN_REQ = 1'h0, RANGE_LOW_SEL = 1'h0, WAKE_HSI_SEL = 1'h0;
    logic STANDBY_RETENTION_BIT = 1'h0, KEEP_SLOW_INTERNAL = 1'h1, KEEP_SLOW_EXTERNAL = 1'h1, DETECTOR_EN = 1'h1;
    logic SWITCHED_SEL = 1'h0, VBAT_MON_EN = 1'h0, INTERRUPT = 1'h0, HSI_WAKE_REQ = 1'h0;
    logic supply_on = 1'h1, pin_req = 1'h0, alarm_req = 1'h0, MAIN_SUPPLY_OK, WAKE_PIN, RTC_ALARM;
    logic [2:0] LP_MODE_SEL = 3'h0, DETECTOR_LEVEL = 3'h5, DETECTOR_THRESH;
    logic [25:0] SYSCLK_HZ = 26'h7a_1200, WAKE_CLK_HZ;
    lpmc_mode_e MODE;
    lpmc_power_s POWER;
    logic RANGE_LOW, FLASH_SLOW_READ, FLASH_PROG_OK, CLOCK_LIMIT_ERR, WAKE_CLK_HSI, DETECTOR_ON;
    logic SUPPLY_MONITOR_ON, SWITCHED_MODE, ON_BATTERY, VBAT_DIVIDER_EN;
    logic [4:0] VBAT_ADC_CHANNEL;
    lpmc_gpio_t [15:0] GPIO_MODE;
    int err_count = 0;
    int n_compared = 0;

    // ----------------------------------------
    // design, far side and clock
    // ----------------------------------------
    lpmc_top #(.WAKE_CYCLES(2)) u_dut (.CORE_CLK, .RST, .SLEEP_REQ, .DEEP_SLEEP, .LP_MODE_SEL, .LP_RUN_REQ,
        .SYSCLK_HZ, .RANGE_LOW_SEL, .WAKE_HSI_SEL, .STANDBY_RETENTION_BIT, .KEEP_SLOW_INTERNAL, .KEEP_SLOW_EXTERNAL,
        .DETECTOR_EN, .DETECTOR_LEVEL, .SWITCHED_SEL, .VBAT_MON_EN, .INTERRUPT, .WAKE_PIN, .RTC_ALARM,
        .MAIN_SUPPLY_OK, .HSI_WAKE_REQ, .MODE, .POWER, .RANGE_LOW, .FLASH_SLOW_READ, .FLASH_PROG_OK,
        .CLOCK_LIMIT_ERR, .WAKE_CLK_HZ, .WAKE_CLK_HSI, .DETECTOR_ON, .DETECTOR_THRESH, .SUPPLY_MONITOR_ON,
        .SWITCHED_MODE, .ON_BATTERY, .VBAT_DIVIDER_EN, .VBAT_ADC_CHANNEL, .GPIO_MODE);
    lpmc_far_model u_far (.clk(CORE_CLK), .supply_on, .pin_req, .alarm_req,
        .main_supply_ok(MAIN_SUPPLY_OK), .wake_pin(WAKE_PIN), .rtc_alarm(RTC_ALARM));

    // 25 ns core clock
    initial
    begin
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    // hang guard, far beyond the planned run
    initial
    begin
        #500000;
        err_count++;
        wrap_up();
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge CORE_CLK);
        #2;
    endtask : step

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // mode chosen a cycle ahead, request held for one cycle
    task automatic go_mode(input logic deep, input logic [2:0] sel);
        LP_MODE_SEL = sel;
        DEEP_SLEEP = deep;
        step(1);
        SLEEP_REQ = 1'h1;
        step(1);
        SLEEP_REQ = 1'h0;
        step(2);
    endtask : go_mode

    task automatic wait_run();
        int i;
        for (i = 0; i < 80 && MODE !== LPMC_RUN; i++)
            step(1);
        chk("mode back to run", LPMC_RUN, MODE);
    endtask : wait_run

    task automatic wrap_up();
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        int i;
        logic [2:0] sel;
        lpmc_mode_e exp_mode;
        repeat (5) @(posedge CORE_CLK);
        #2;
        chk("reset mode", LPMC_RUN, MODE);
        chk("reset supplies", 14'h3fff, POWER);
        chk("pins in reset", 32'hffff_ffff, GPIO_MODE);
        RST = 1'h0;
        step(10);
        chk("reset range", 1'h0, RANGE_LOW);
        chk("linear after reset", 1'h0, SWITCHED_MODE);
        chk("pins after reset", 32'hffff_ffff, GPIO_MODE);
        RANGE_LOW_SEL = 1'h1;
        SYSCLK_HZ = 26'h131_2d00;
        step(3);
        chk("slow flash read", 1'h1, FLASH_SLOW_READ && RANGE_LOW && FLASH_PROG_OK);
        chk("over 16 MHz", 1'h1, CLOCK_LIMIT_ERR);
        SYSCLK_HZ = 26'hf4_2400;
        step(3);
        chk("at 16 MHz", 1'h0, CLOCK_LIMIT_ERR);
        RANGE_LOW_SEL = 1'h0;
        SYSCLK_HZ = 26'h2dc_6c00;
        step(3);
        chk("fast flash read", 1'h0, FLASH_SLOW_READ || CLOCK_LIMIT_ERR);
        SWITCHED_SEL = 1'h1;
        VBAT_MON_EN = 1'h1;
        step(4);
        chk("switched wins", 1'h1, SWITCHED_MODE);
        chk("battery channel", {1'h1, 5'h0e}, {VBAT_DIVIDER_EN, VBAT_ADC_CHANNEL});
        go_mode(1'h0, 3'h0);
        chk("sleep not low_power_sleep", LPMC_SLEEP, MODE);
        chk("sleep clocks", 2'h1, {POWER.cpu_clk, POWER.periph_clk});
        INTERRUPT = 1'h1;
        step(2);
        INTERRUPT = 1'h0;
        wait_run();
        SYSCLK_HZ = 26'h1e_8480;
        LP_RUN_REQ = 1'h1;
        step(3);
        chk("low_power_run at 2 MHz", LPMC_RUN, MODE);
        SYSCLK_HZ = 26'hf_4240;
        step(3);
        chk("low_power_run", LPMC_LOW_POWER_RUN, MODE);
        go_mode(1'h0, 3'h0);
        chk("low_power_sleep", LPMC_LOW_POWER_SLEEP, MODE);
        LP_RUN_REQ = 1'h0;
        INTERRUPT = 1'h1;
        step(2);
        INTERRUPT = 1'h0;
        wait_run();
        SYSCLK_HZ = 26'h7a_1200;
        // every deep code, reserved code 5, and standby without retention
        for (i = 0; i < 7; i++)
        begin
            sel = (i == 6) ? 3'h3 : 3'(i);
            STANDBY_RETENTION_BIT = (i != 6);
            WAKE_HSI_SEL = i[0];
            HSI_WAKE_REQ = (sel == 3'h2);
            exp_mode = (sel > 3'h4) ? LPMC_STOP0 : lpmc_mode_e'(4'h4 + {1'h0, sel});
            go_mode(1'h1, sel);
            step(6);
            chk("deep mode", exp_mode, MODE);
            chk("main regulator", exp_mode == LPMC_STOP0, POWER.main_regulator);
            chk("slow crystal kept", 1'h1, POWER.slow_external_crystal);
            chk("monitors", {2{sel != 3'h4}}, {SUPPLY_MONITOR_ON, DETECTOR_ON});
            if (exp_mode < LPMC_STANDBY)
                chk("fast rc request", sel == 3'h2, POWER.fast_internal_rc);
            else
                chk("core and bank two", {1'h0, STANDBY_RETENTION_BIT && sel == 3'h3},
                    {POWER.core_supply_domain, POWER.sram_bank_two});
            if (sel == 3'h3)
                chk("standby threshold", 3'h0, DETECTOR_THRESH);
            pin_req = 1'h1;
            step(8);
            pin_req = 1'h0;
            step(6);
            wait_run();
            chk("wake on fast rc", exp_mode < LPMC_STANDBY && WAKE_HSI_SEL, WAKE_CLK_HSI);
            chk("wake clock", (exp_mode < LPMC_STANDBY) ? SYSCLK_HZ : 26'h3d_0900, WAKE_CLK_HZ);
        end
        supply_on = 1'h0;
        step(10);
        chk("on battery", 1'h1, ON_BATTERY);
        go_mode(1'h1, 3'h1);
        pin_req = 1'h1;
        alarm_req = 1'h1;
        INTERRUPT = 1'h1;
        step(10);
        chk("no wake on battery", LPMC_STOP1, MODE);
        pin_req = 1'h0;
        alarm_req = 1'h0;
        INTERRUPT = 1'h0;
        supply_on = 1'h1;
        step(10);
        chk("supply back", 1'h0, ON_BATTERY);
        pin_req = 1'h1;
        step(8);
        pin_req = 1'h0;
        wait_run();
        wrap_up();
    end
endmodule : lpmc_top_tb

`default_nettype wire
